// >>> rtl/ref_front.sv
// Reference selection, phase step absorption and delay clear for the DPLL front end.
`timescale 1ns/10ps
module ref_front #(
  parameter int SLEW_CYCLES = sync_front_pkg::SLEW_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [sync_front_pkg::AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [sync_front_pkg::AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic device_reset_n,
  input wire logic primary_ref,
  input wire logic secondary_ref,
  input wire logic frame_pulse_8k,
  input wire logic mode_select_low,
  input wire logic mode_select_high,
  input wire logic source_choice,
  input wire logic freq_sel_hi,
  input wire logic freq_sel_lo,
  input wire logic guard_time_in,
  input wire logic delay_clear_n,
  input wire logic internal_tie_pin,
  input wire logic dpll_feedback,
  output logic virtual_edge,
  output logic holdover,
  output logic out_clock
);
  import sync_front_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // Core state.

  logic rst;
  assign rst = !aresetn || !device_reset_n;

  mode_e state_q, state_d;
  logic fp_q, fp_d;
  logic pri_q, pri_d;
  logic sec_q, sec_d;
  logic fb_q, fb_d;
  logic sel_sec_q, sel_sec_d;
  logic meas_run_q, meas_run_d;
  logic [DW-1:0] meas_q, meas_d;
  logic [DW-1:0] delay_q, delay_d;
  logic [DW-1:0] period_q, period_d;
  logic fs_err_q, fs_err_d;
  logic clearing_q, clearing_d;
  logic [4:0] clr_cnt_q, clr_cnt_d;
  logic [15:0] slew_cnt_q, slew_cnt_d;
  logic virt_q, virt_d;
  logic hold_q, hold_d;
  logic oclk_q, oclk_d;
  logic sw_clr;
  logic [DW:0] sum;
  logic [DW-1:0] half;

  delay_if dl ();

  delay_line u_delay_line (
    .aclk(aclk),
    .rst(rst),
    .dl(dl.line)
  );

  // Only the selected reference reaches the delay line, on its falling edge.
  assign dl.ref_fall = sel_sec_q ? (sec_q && !secondary_ref) : (pri_q && !primary_ref);
  assign dl.delay = delay_q;

  always_comb begin
    logic fp_rise;
    logic fb_fall;
    logic want_sec;
    logic [1:0] mode;
    logic clr_start;
    fp_rise = frame_pulse_8k && !fp_q;
    fb_fall = fb_q && !dpll_feedback;
    mode = {mode_select_high, mode_select_low};
    clr_start = 1'b0;
    // Automatic sequencing on loss inputs lives elsewhere; here it holds the primary.
    want_sec = (mode != MODE_AUTO) && source_choice;
    state_d = state_q;
    sel_sec_d = sel_sec_q;
    meas_run_d = meas_run_q;
    meas_d = meas_q;
    delay_d = delay_q;
    period_d = period_q;
    fs_err_d = fs_err_q;
    clearing_d = clearing_q;
    clr_cnt_d = clr_cnt_q;
    slew_cnt_d = slew_cnt_q;
    fp_d = frame_pulse_8k;
    pri_d = primary_ref;
    sec_d = secondary_ref;
    fb_d = dpll_feedback;
    // The edge that ends the count belongs to the offset, so the load matches the stored count.
    sum = {1'b0, delay_q} + {1'b0, meas_q} + {{DW{1'b0}}, 1'b1};
    half = period_q >> 1;

    if (fp_rise) begin
      case (mode)
        MODE_FREE: state_d = ST_FREERUN;
        MODE_HOLD: state_d = ST_HOLD;
        default: begin
          case (state_q)
            ST_NORMAL: begin
              if (want_sec != sel_sec_q) begin
                state_d = ST_SWITCH;
                sel_sec_d = want_sec;
                meas_run_d = 1'b0;
              end
            end
            ST_HOLD: begin
              sel_sec_d = want_sec;
              meas_run_d = 1'b0;
              state_d = guard_time_in ? ST_SWITCH : ST_NORMAL;
            end
            ST_FREERUN: begin
              sel_sec_d = want_sec;
              state_d = ST_NORMAL;
            end
            default: ;
          endcase
        end
      endcase
    end

    // Offset runs from the new reference edge to the next feedback edge.
    if (state_q == ST_SWITCH && state_d == ST_SWITCH) begin
      if (meas_run_q) begin
        meas_d = meas_q + DW'(1);
        if (fb_fall) begin
          meas_run_d = 1'b0;
          state_d = ST_NORMAL;
          if (sum >= {1'b0, period_q}) begin
            delay_d = DW'(sum - {1'b0, period_q});
          end else begin
            delay_d = sum[DW-1:0];
          end
        end
      end else if (dl.ref_fall) begin
        meas_run_d = 1'b1;
        meas_d = '0;
      end
    end

    if (!delay_clear_n) begin
      if (clr_cnt_q != 5'(CLEAR_CYC)) begin
        clr_cnt_d = clr_cnt_q + 5'h01;
      end
      if (clr_cnt_q == 5'(CLEAR_CYC - 1)) begin
        clearing_d = 1'b1;
        clr_start = 1'b1;
        slew_cnt_d = '0;
      end
    end else begin
      clr_cnt_d = '0;
    end
    if (sw_clr) begin
      clearing_d = 1'b1;
      clr_start = 1'b1;
      slew_cnt_d = '0;
    end

    // Walking the delay back one cycle at a time keeps the DPLL inside its slope limit.
    // A new clear request wins over the end of a walk that falls in the same cycle.
    if (clearing_q && !clr_start) begin
      if (delay_q == '0) begin
        clearing_d = 1'b0;
      end else if (slew_cnt_q == 16'(SLEW_CYCLES - 1)) begin
        slew_cnt_d = '0;
        if (delay_q > half) begin
          delay_d = (delay_q + DW'(1) >= period_q) ? '0 : delay_q + DW'(1);
        end else begin
          delay_d = delay_q - DW'(1);
        end
      end else begin
        slew_cnt_d = slew_cnt_q + 16'h0001;
      end
    end

    virt_d = dl.virt_fall && (state_q == ST_NORMAL);
    hold_d = (state_d == ST_HOLD) || (state_d == ST_SWITCH);
    oclk_d = dpll_feedback;

    if (rst) begin
      // Frequency selection is caught while the device is held in reset.
      case ({freq_sel_hi, freq_sel_lo})
        FS_1544K: period_d = PER_1544K;
        FS_2048K: period_d = PER_2048K;
        default: period_d = PER_8K;
      endcase
      fs_err_d = ({freq_sel_hi, freq_sel_lo} == FS_RSVD);
    end
  end

  always_ff @(posedge aclk) begin
    if (rst) begin
      state_q <= ST_NORMAL;
      sel_sec_q <= 1'b0;
      meas_run_q <= 1'b0;
      meas_q <= '0;
      delay_q <= '0;
      clearing_q <= 1'b0;
      clr_cnt_q <= '0;
      slew_cnt_q <= '0;
      fp_q <= 1'b0;
      pri_q <= 1'b0;
      sec_q <= 1'b0;
      fb_q <= 1'b0;
      virt_q <= 1'b0;
      hold_q <= 1'b0;
      oclk_q <= 1'b1;
    end else begin
      state_q <= state_d;
      sel_sec_q <= sel_sec_d;
      meas_run_q <= meas_run_d;
      meas_q <= meas_d;
      delay_q <= delay_d;
      clearing_q <= clearing_d;
      clr_cnt_q <= clr_cnt_d;
      slew_cnt_q <= slew_cnt_d;
      fp_q <= fp_d;
      pri_q <= pri_d;
      sec_q <= sec_d;
      fb_q <= fb_d;
      virt_q <= virt_d;
      hold_q <= hold_d;
      oclk_q <= oclk_d;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      period_q <= PER_8K;
      fs_err_q <= 1'b0;
    end else begin
      period_q <= period_d;
      fs_err_q <= fs_err_d;
    end
  end

  assign virtual_edge = virt_q;
  assign holdover = hold_q;
  assign out_clock = oclk_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Register bus slave.

  logic aw_have_q, aw_have_d;
  logic [AW-1:0] aw_addr_q, aw_addr_d;
  logic w_have_q, w_have_d;
  logic [31:0] w_data_q, w_data_d;
  logic w_strb0_q, w_strb0_d;
  logic awready_q, awready_d;
  logic wready_q, wready_d;
  logic bvalid_q, bvalid_d;
  logic [1:0] bresp_q, bresp_d;
  logic arready_q, arready_d;
  logic rvalid_q, rvalid_d;
  logic [1:0] rresp_q, rresp_d;
  logic [31:0] rdata_q, rdata_d;
  logic sw_clr_q, sw_clr_d;
  logic [31:0] status;

  assign sw_clr = sw_clr_q;

  always_comb begin
    status = '0;
    status[ST_HOLD_BIT] = hold_q;
    status[ST_SEC_BIT] = sel_sec_q;
    status[ST_FREE_BIT] = (state_q == ST_FREERUN);
    status[ST_SWITCH_BIT] = (state_q == ST_SWITCH);
    status[ST_CLEAR_BIT] = clearing_q;
    status[ST_FSERR_BIT] = fs_err_q;
    status[ST_TIE_BIT] = internal_tie_pin;
    aw_have_d = aw_have_q;
    aw_addr_d = aw_addr_q;
    w_have_d = w_have_q;
    w_data_d = w_data_q;
    w_strb0_d = w_strb0_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    rvalid_d = rvalid_q;
    rresp_d = rresp_q;
    rdata_d = rdata_q;
    sw_clr_d = 1'b0;
    if (s_axi_awvalid && awready_q) begin
      aw_have_d = 1'b1;
      aw_addr_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready_q) begin
      w_have_d = 1'b1;
      w_data_d = s_axi_wdata;
      w_strb0_d = s_axi_wstrb[0];
    end
    if (bvalid_q && s_axi_bready) begin
      bvalid_d = 1'b0;
    end
    if (aw_have_q && w_have_q && !bvalid_q) begin
      aw_have_d = 1'b0;
      w_have_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = RESP_OKAY;
      case (aw_addr_q)
        REG_CTRL: sw_clr_d = w_strb0_q && w_data_q[CTRL_CLR_BIT];
        REG_STATUS, REG_DELAY, REG_MEAS: ;
        default: bresp_d = RESP_SLVERR;
      endcase
    end
    if (rvalid_q && s_axi_rready) begin
      rvalid_d = 1'b0;
    end
    if (s_axi_arvalid && arready_q) begin
      rvalid_d = 1'b1;
      rresp_d = RESP_OKAY;
      case (s_axi_araddr)
        REG_CTRL: rdata_d = '0;
        REG_STATUS: rdata_d = status;
        REG_DELAY: rdata_d = 32'(delay_q);
        REG_MEAS: rdata_d = 32'(meas_q);
        default: begin
          rdata_d = '0;
          rresp_d = RESP_SLVERR;
        end
      endcase
    end
    awready_d = !aw_have_d;
    wready_d = !w_have_d;
    arready_d = !rvalid_d;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      aw_addr_q <= '0;
      w_have_q <= 1'b0;
      w_data_q <= '0;
      w_strb0_q <= 1'b0;
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rresp_q <= RESP_OKAY;
      rdata_q <= '0;
      sw_clr_q <= 1'b0;
    end else begin
      aw_have_q <= aw_have_d;
      aw_addr_q <= aw_addr_d;
      w_have_q <= w_have_d;
      w_data_q <= w_data_d;
      w_strb0_q <= w_strb0_d;
      awready_q <= awready_d;
      wready_q <= wready_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      arready_q <= arready_d;
      rvalid_q <= rvalid_d;
      rresp_q <= rresp_d;
      rdata_q <= rdata_d;
      sw_clr_q <= sw_clr_d;
    end
  end

  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rresp = rresp_q;
  assign s_axi_rdata = rdata_q;
endmodule

// >>> rtl/sync_front_pkg.sv
// Constants, codes and types shared by the reference front end.
package sync_front_pkg;
  localparam int CLK_HZ = 50_000_000;
  localparam int CLK_PERIOD_NS = 20;
  localparam int DW = 13;
  localparam logic [DW-1:0] PER_8K = DW'(CLK_HZ / 8_000);
  localparam logic [DW-1:0] PER_1544K = DW'(CLK_HZ / 1_544_000);
  localparam logic [DW-1:0] PER_2048K = DW'(CLK_HZ / 2_048_000);
  localparam logic [1:0] FS_RSVD = 2'h0;
  localparam logic [1:0] FS_8K = 2'h1;
  localparam logic [1:0] FS_1544K = 2'h2;
  localparam logic [1:0] FS_2048K = 2'h3;
  localparam logic [1:0] MODE_NORMAL = 2'h0;
  localparam logic [1:0] MODE_HOLD = 2'h1;
  localparam logic [1:0] MODE_FREE = 2'h2;
  localparam logic [1:0] MODE_AUTO = 2'h3;
  localparam int CLEAR_MIN_NS = 300;
  localparam int CLEAR_CYC = (CLEAR_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SLEW_STEP_NS = 5;
  localparam int SLEW_WINDOW_NS = 125_000;
  localparam int SLEW_CYC = (SLEW_WINDOW_NS * CLK_PERIOD_NS / SLEW_STEP_NS) / CLK_PERIOD_NS;
  localparam int AW = 8;
  localparam logic [AW-1:0] REG_CTRL = 8'h00;
  localparam logic [AW-1:0] REG_STATUS = 8'h04;
  localparam logic [AW-1:0] REG_DELAY = 8'h08;
  localparam logic [AW-1:0] REG_MEAS = 8'h0C;
  localparam int CTRL_CLR_BIT = 0;
  localparam int ST_HOLD_BIT = 0;
  localparam int ST_SEC_BIT = 1;
  localparam int ST_FREE_BIT = 2;
  localparam int ST_SWITCH_BIT = 3;
  localparam int ST_CLEAR_BIT = 4;
  localparam int ST_FSERR_BIT = 5;
  localparam int ST_TIE_BIT = 6;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {ST_NORMAL, ST_HOLD, ST_SWITCH, ST_FREERUN} mode_e;
endpackage

// >>> rtl/delay_if.sv
// Link between the front end and its programmable delay line.
`timescale 1ns/10ps
interface delay_if;
  import sync_front_pkg::*;
  logic ref_fall;
  logic [DW-1:0] delay;
  logic virt_fall;
  modport ctl (output ref_fall, output delay, input virt_fall);
  modport line (input ref_fall, input delay, output virt_fall);
endinterface

// >>> rtl/delay_line.sv
// Programmable delay that re-times reference falling edges.
`timescale 1ns/10ps
module delay_line (
  input wire logic aclk,
  input wire logic rst,
  delay_if.line dl
);
  import sync_front_pkg::*;

  logic [DW-1:0] cnt_q, cnt_d;
  logic busy_q, busy_d;
  logic fire_q, fire_d;

  // The delay stays below one reference period, so one pending edge is enough.
  always_comb begin
    cnt_d = cnt_q;
    busy_d = busy_q;
    fire_d = 1'b0;
    if (busy_q) begin
      if (cnt_q <= DW'(1)) begin
        busy_d = 1'b0;
        fire_d = 1'b1;
      end else begin
        cnt_d = cnt_q - DW'(1);
      end
    end
    if (dl.ref_fall) begin
      if (dl.delay == '0) begin
        fire_d = 1'b1;
        busy_d = 1'b0;
      end else begin
        cnt_d = dl.delay;
        busy_d = 1'b1;
      end
    end
    // Two fires a cycle apart are one edge carried across the period wrap while the delay
    // slews upward; dropping the second keeps the virtual reference step to one cycle.
    if (fire_q) begin
      fire_d = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (rst) begin
      cnt_q <= '0;
      busy_q <= 1'b0;
      fire_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      busy_q <= busy_d;
      fire_q <= fire_d;
    end
  end

  assign dl.virt_fall = fire_q;
endmodule

// >>> test/ref_front_sva.sv
// Port-level concurrent checks for the reference front end.
`timescale 1ns/10ps
module ref_front_sva (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic device_reset_n,
  input wire logic dpll_feedback,
  input wire logic virtual_edge,
  input wire logic holdover,
  input wire logic out_clock
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  a_reset_clock_high: assert property (!device_reset_n |=> out_clock)
    else $error("clock output low during device reset");
  a_reset_quiet: assert property (!device_reset_n |=> !virtual_edge && !holdover)
    else $error("edge or holdover during device reset");
  a_clock_follow: assert property (device_reset_n |=> out_clock == $past(dpll_feedback))
    else $error("clock output does not follow feedback");
  a_edge_single: assert property (virtual_edge |=> !virtual_edge)
    else $error("virtual edge wider than one cycle");
  a_hold_no_edge: assert property (holdover && $past(holdover) |-> !virtual_edge)
    else $error("virtual edge passed during holdover");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
    s_axi_wready |-> ##[1:2] s_axi_bvalid)
    else $error("write response late");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  a_bresp_held: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  a_rdata_held: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  a_read_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("address accepted while data pending");
  a_bus_wakeup: assert property ($rose(aresetn) |-> !s_axi_bvalid && !s_axi_rvalid
    ##1 s_axi_awready && s_axi_arready)
    else $error("bus slave not idle after reset");
  c_read: cover property (s_axi_rvalid && s_axi_rready);
  c_hold_exit: cover property ($fell(holdover));
  c_edge: cover property (virtual_edge);
endmodule
bind ref_front ref_front_sva ref_front_sva_inst (.aclk, .aresetn, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
  .device_reset_n, .dpll_feedback, .virtual_edge, .holdover, .out_clock);

// >>> test/ref_partner.sv
// Far-side model: two references, frame pulse and DPLL feedback.
`timescale 1ns/10ps
module ref_partner #(
  parameter int PER = 24,
  parameter int SEC_OFS = 7,
  parameter int FB_OFS = 3,
  parameter int FRAME = 240
) (
  input wire logic aclk,
  output logic primary_ref,
  output logic secondary_ref,
  output logic frame_pulse_8k,
  output logic dpll_feedback
);
  int cnt = 0;
  int fcnt = 0;
  initial begin
    primary_ref = 1'b0;
    secondary_ref = 1'b0;
    frame_pulse_8k = 1'b0;
    dpll_feedback = 1'b0;
  end
  // One counter drives both references, so their frequencies can never drift apart.
  // The frame is far shorter than 8 kHz to keep mode changes cheap in simulation.
  always @(posedge aclk) begin
    cnt <= (cnt + 1) % PER;
    fcnt <= (fcnt + 1) % FRAME;
    primary_ref <= cnt < PER / 2;
    secondary_ref <= ((cnt + SEC_OFS) % PER) < PER / 2;
    dpll_feedback <= ((cnt + FB_OFS) % PER) < PER / 2;
    frame_pulse_8k <= fcnt < 4;
  end
endmodule

// >>> test/ref_front_tb_top.sv
// Self-checking testbench for the reference front end.
`timescale 1ns/10ps
module ref_front_tb_top;
  import sync_front_pkg::*;
  localparam int P = int'(PER_2048K);
  localparam int SO = 7;
  localparam int FO = 3;
  localparam int M_SEC = (SO - FO + P) % P;
  localparam int M_PRI = (P - FO) % P;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [AW-1:0] s_axi_awaddr = '0;
  logic [AW-1:0] s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic device_reset_n = 1'b0, mode_select_low = 1'b0, mode_select_high = 1'b0;
  logic source_choice = 1'b0, freq_sel_hi = 1'b0, freq_sel_lo = 1'b0;
  logic guard_time_in = 1'b0, delay_clear_n = 1'b1, internal_tie_pin = 1'b0;
  logic primary_ref, secondary_ref, frame_pulse_8k, dpll_feedback;
  logic virtual_edge, holdover, out_clock;
  logic [33:0] rq[$];
  logic [1:0] bq[$];
  logic [AW-1:0] aq[$];
  logic [31:0] seed = 32'h191AB29E;
  int err_count = 0;
  int comparisons = 0;

  always #10 aclk = ~aclk;

  ref_partner #(.PER(P), .SEC_OFS(SO), .FB_OFS(FO), .FRAME(240)) ref_partner_inst (
    .aclk(aclk), .primary_ref(primary_ref), .secondary_ref(secondary_ref),
    .frame_pulse_8k(frame_pulse_8k), .dpll_feedback(dpll_feedback));
  ref_front #(.SLEW_CYCLES(40)) ref_front_inst (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .device_reset_n(device_reset_n),
    .primary_ref(primary_ref), .secondary_ref(secondary_ref),
    .frame_pulse_8k(frame_pulse_8k), .mode_select_low(mode_select_low),
    .mode_select_high(mode_select_high), .source_choice(source_choice),
    .freq_sel_hi(freq_sel_hi), .freq_sel_lo(freq_sel_lo), .guard_time_in(guard_time_in),
    .delay_clear_n(delay_clear_n), .internal_tie_pin(internal_tie_pin),
    .dpll_feedback(dpll_feedback), .virtual_edge(virtual_edge), .holdover(holdover),
    .out_clock(out_clock));

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic complete_run();
    if (err_count == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input logic [AW-1:0] a, input logic [33:0] got, input logic [33:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH resp_data at %h expected %h seen %h", a, exp, got);
    end
  endtask

  // Bus reset lasts 5 edges; the device reset stays low 15 edges, i.e. 300 ns.
  task automatic rst(input logic [1:0] fs);
    @(posedge aclk);
    aresetn <= 1'b0;
    device_reset_n <= 1'b0;
    freq_sel_hi <= fs[1];
    freq_sel_lo <= fs[0];
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (10) @(posedge aclk);
    device_reset_n <= 1'b1;
    repeat (2) @(posedge aclk);
  endtask

  task automatic wr(input logic [AW-1:0] a, input logic [31:0] d, input logic [1:0] e);
    logic aw;
    logic w;
    aw = 1'b1;
    w = 1'b1;
    bq.push_back(e);
    aq.push_back(a);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (aw || w) begin
      @(posedge aclk);
      if (aw && s_axi_awready === 1'b1) begin
        s_axi_awvalid <= 1'b0;
        aw = 1'b0;
      end
      if (w && s_axi_wready === 1'b1) begin
        s_axi_wvalid <= 1'b0;
        w = 1'b0;
      end
    end
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [AW-1:0] a, input logic [31:0] d, input logic [1:0] e);
    rq.push_back({e, d});
    aq.push_back(a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    while (s_axi_rvalid !== 1'b1) @(posedge aclk);
    s_axi_rready <= 1'b0;
  endtask

  task automatic wait_frame();
    @(posedge frame_pulse_8k);
    repeat (4) @(posedge aclk);
  endtask

  // Bounded wait for the measure-and-load step to hand back to normal tracking.
  task automatic settle();
    int n;
    n = 0;
    while (holdover === 1'b1 && n < 200) begin
      @(posedge aclk);
      n++;
    end
    repeat (2) @(posedge aclk);
  endtask

  // A selected falling edge seen at one edge shows as a virtual edge 2 + delay edges later.
  task automatic edge_gap(input logic use_sec, input int d);
    int n;
    logic prev;
    logic cur;
    n = 0;
    cur = use_sec ? secondary_ref : primary_ref;
    do begin
      prev = cur;
      @(posedge aclk);
      cur = use_sec ? secondary_ref : primary_ref;
    end while (!(prev === 1'b1 && cur === 1'b0));
    do begin
      @(posedge aclk);
      n++;
    end while (virtual_edge !== 1'b1 && n < 64);
    comparisons++;
    if (n != d + 2) begin
      err_count++;
      $display("MISMATCH edge_gap expected %0d seen %0d", d + 2, n);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge aclk) begin
    if (s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1)
      chk(aq.pop_front(), {s_axi_bresp, 32'h0}, {bq.pop_front(), 32'h0});
    if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1)
      chk(aq.pop_front(), {s_axi_rresp, s_axi_rdata}, rq.pop_front());
  end

  initial begin
    repeat (20000) @(posedge aclk);
    err_count++;
    complete_run();
  end

  initial begin
    int de;
    logic [1:0] m;
    rst(2'b00);
    rd(REG_STATUS, 32'h1 << ST_FSERR_BIT, RESP_OKAY);
    rst(2'b11);
    rd(REG_DELAY, 32'h0, RESP_OKAY);
    rd(REG_MEAS, 32'h0, RESP_OKAY);
    edge_gap(1'b0, 0);
    internal_tie_pin <= 1'b1;
    rd(REG_STATUS, 32'h1 << ST_TIE_BIT, RESP_OKAY);
    internal_tie_pin <= 1'b0;
    wr(REG_CTRL, xs() & 32'hFFFFFFFE, RESP_OKAY);
    rd(REG_CTRL, 32'h0, RESP_OKAY);
    wr(8'h10, xs(), RESP_SLVERR);
    rd(8'h10, 32'h0, RESP_SLVERR);
    source_choice <= 1'b1;
    wait_frame();
    settle();
    rd(REG_MEAS, 32'(M_SEC), RESP_OKAY);
    rd(REG_DELAY, 32'(M_SEC), RESP_OKAY);
    edge_gap(1'b1, M_SEC);
    rd(REG_STATUS, 32'h1 << ST_SEC_BIT, RESP_OKAY);
    source_choice <= 1'b0;
    wait_frame();
    settle();
    de = (M_SEC + M_PRI) % P;
    rd(REG_DELAY, 32'(de), RESP_OKAY);
    rd(REG_STATUS, 32'h0, RESP_OKAY);
    // Freerun, holdover without guard, then holdover with guard.
    for (int i = 0; i < 3; i++) begin
      m = (i == 0) ? 2'b10 : 2'b01;
      mode_select_high <= m[1];
      mode_select_low <= m[0];
      guard_time_in <= (i == 2);
      wait_frame();
      rd(REG_STATUS, m[1] ? 32'h1 << ST_FREE_BIT : 32'h1 << ST_HOLD_BIT, RESP_OKAY);
      mode_select_high <= 1'b0;
      mode_select_low <= 1'b0;
      wait_frame();
      settle();
      if (i == 2) de = (de + M_PRI) % P;
      rd(REG_DELAY, 32'(de), RESP_OKAY);
    end
    delay_clear_n <= 1'b0;
    repeat (10) @(posedge aclk);
    delay_clear_n <= 1'b1;
    repeat (5) @(posedge aclk);
    rd(REG_DELAY, 32'(de), RESP_OKAY);
    delay_clear_n <= 1'b0;
    repeat (20) @(posedge aclk);
    delay_clear_n <= 1'b1;
    // Going the long way round would need far more slew steps than fit in this wait.
    repeat (200) @(posedge aclk);
    rd(REG_DELAY, 32'h0, RESP_OKAY);
    // Software clear walks a short delay down; then automatic control stays on primary.
    source_choice <= 1'b1;
    wait_frame();
    settle();
    rd(REG_DELAY, 32'(M_SEC), RESP_OKAY);
    wr(REG_CTRL, 32'h1, RESP_OKAY);
    rd(REG_STATUS, (32'h1 << ST_SEC_BIT) | (32'h1 << ST_CLEAR_BIT), RESP_OKAY);
    repeat (200) @(posedge aclk);
    rd(REG_DELAY, 32'h0, RESP_OKAY);
    source_choice <= 1'b0;
    mode_select_high <= 1'b1;
    mode_select_low <= 1'b1;
    rst(2'b11);
    wait_frame();
    rd(REG_STATUS, 32'h0, RESP_OKAY);
    complete_run();
  end
endmodule
